/* File: pgw_consts.svh */
`ifndef PGW_CONSTS_SVH
`define PGW_CONSTS_SVH

// register offsets
`define PGW_OFS_GATE_A     4'h0
`define PGW_OFS_GATE_B     4'h1
`define PGW_OFS_GATE_C     4'h2
`define PGW_OFS_CTRL       4'h3
`define PGW_OFS_STAT       4'h4

// control register fields
`define PGW_CTRL_IDLE      0
`define PGW_CTRL_TWO_SPEED 1
`define PGW_CTRL_FAILSAFE  2
`define PGW_CTRL_SRC_LO    3
`define PGW_CTRL_INTERNAL_FREQ_SELECT_LO   5

// status register fields
`define PGW_STAT_PRI_RUN   0
`define PGW_STAT_FAST_INT  1
`define PGW_STAT_MID_INT   2
`define PGW_STAT_ASLEEP    3
`define PGW_STAT_WAKE_IRQ  4
`define PGW_STAT_WAKE_WDT  5

// reset values; freq select loaded by sleep or clear instruction while running on the internal source
`define PGW_GATE_RST       8'h00
`define PGW_CTRL_RST       8'h00
`define PGW_INTERNAL_FREQ_SELECT_ON_CLEAR  3'h3

// timing
`define PGW_CLK_PERIOD_NS  25
`define PGW_CPU_READY_NS   1000
`define PGW_CPU_READY_CYC  ((`PGW_CPU_READY_NS + `PGW_CLK_PERIOD_NS - 1) / `PGW_CLK_PERIOD_NS)

`endif

/* File: pgw_pkg.sv */
package pgw_pkg;

    typedef enum logic [1:0] {
        PGW_SRC_XTAL = 2'h0,
        PGW_SRC_PLL  = 2'h1,
        PGW_SRC_EXT  = 2'h2,
        PGW_SRC_INT  = 2'h3
    } pgw_src_e;

    typedef enum logic [3:0] {
        PGW_ST_BOOT  = 4'h1,
        PGW_ST_RUN   = 4'h2,
        PGW_ST_SLEEP = 4'h4,
        PGW_ST_WAKE  = 4'h8
    } pgw_state_e;

    typedef struct packed {
        logic [7:0] c;
        logic [7:0] b;
        logic [7:0] a;
    } pgw_gate_s;

    typedef struct packed {
        logic mid_int;
        logic fast_int;
        logic pri_run;
    } pgw_flags_s;

endpackage

/* File: pgw_gate_wake.sv */
// Functional notes
// - set gate bit stops that peripheral's clock
// - gated peripheral ignores register writes
// - function enable stops function, registers stay
// - gate bit holds peripheral registers in reset
// - third register bits 7-4 read zero
// - modulator gate only on largest package
// - second register gates port, charge, adc, timers
// - parallel port gate absent on smallest package
// - first register gates capcmp and serial ports
// - wake only by irq, reset, watchdog
// - enabled pending interrupt starts wake sequence
// - branch to vector only if global enable
// - watchdog wakes when asleep, resets when running
// - sleep or clear instr clears watchdog, clock
// - reset exit waits primary clock, sets flag
// - two-speed runs internal until primary ready
// - no startup wait from primary idle, non-crystal
// - cpu ready delay precedes every resume
// - cpu ready delay runs alongside startup wait
`timescale 1ns/100ps
`include "pgw_consts.svh"
`default_nettype none

module pgw_gate_wake
    import pgw_pkg::*;
#(
    parameter int PKG_PINS = 64
)
(
    input  wire logic        clock_i,            // system clock
    input  wire logic        reset_n_i,          // async device reset
    input  wire logic [3:0]  addr_i,             // register address
    input  wire logic [7:0]  wr_data_i,          // write data
    input  wire logic        wr_i,               // write strobe
    input  wire logic        rd_i,               // read strobe
    output logic      [7:0]  rd_data_o,          // read data, next cycle
    input  wire logic [23:0] unit_function_enable_i, // per-unit enable bits
    output logic      [23:0] periph_clk_en_o,    // per-unit clock enable
    output logic      [23:0] periph_hold_o,      // reset held, writes blocked
    output logic      [23:0] periph_active_o,    // unit function running
    input  wire logic        sleep_instr_i,      // sleep instruction pulse
    input  wire logic        wdt_clear_instr_i,  // watchdog clear pulse
    input  wire logic        wdt_timeout_i,      // watchdog time-out pulse
    input  wire logic        irq_wake_i,         // enabled irq flag set
    input  wire logic        global_irq_enable_i, // global irq enable
    input  wire logic        primary_ready_i,    // primary clock ready
    output logic             cpu_run_o,          // cpu may execute
    output logic             cpu_reset_o,        // cpu held in reset
    output logic             irq_branch_o,       // branch to vector pulse
    output logic             wdt_reset_o,        // watchdog reset pulse
    output logic             wdt_clear_o,        // clear watchdog pulse
    output logic             primary_osc_en_o,   // primary oscillator on
    output logic             internal_clk_sel_o  // cpu on internal clock
);

    localparam int READY_CYC = `PGW_CPU_READY_CYC;
    localparam int CW        = $clog2(READY_CYC + 1);
    localparam logic [CW-1:0] READY_LAST = CW'(READY_CYC - 1);
    localparam logic [7:0] MASK_A = 8'hff;
    localparam logic [7:0] MASK_B = (PKG_PINS == 28) ? 8'h7f : 8'hff;
    localparam logic [7:0] MASK_C = (PKG_PINS == 64) ? 8'h0f : 8'h07;

    // register group
    pgw_gate_s  gate_r, gate_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [23:0] clk_en_r, clk_en_nxt;
    logic [23:0] hold_r, hold_nxt;
    logic [23:0] active_r, active_nxt;
    logic [7:0] stat_w;

    // sequencer group
    pgw_state_e state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    pgw_flags_s flags_r, flags_nxt;
    logic idle_r, idle_nxt;
    logic need_ost_r, need_ost_nxt;
    logic pending_r, pending_nxt;
    logic cause_irq_r, cause_irq_nxt;
    logic cause_wdt_r, cause_wdt_nxt;
    logic int_sel_r, int_sel_nxt;
    logic osc_en_r, osc_en_nxt;
    logic run_r, run_nxt;
    logic rst_r, rst_nxt;
    logic branch_r, branch_nxt;
    logic wdt_rst_r, wdt_rst_nxt;
    logic wdt_clr_r, wdt_clr_nxt;

    pgw_src_e src_w;
    logic     two_speed_w;
    logic     instr_w;

    assign src_w       = pgw_src_e'(ctrl_r[`PGW_CTRL_SRC_LO +: 2]);
    assign two_speed_w = ctrl_r[`PGW_CTRL_TWO_SPEED] | ctrl_r[`PGW_CTRL_FAILSAFE];
    assign instr_w     = (sleep_instr_i | wdt_clear_instr_i) && (state_r == PGW_ST_RUN);
    assign stat_w      = {2'h0, cause_wdt_r, cause_irq_r,
                          (state_r == PGW_ST_SLEEP), flags_r.mid_int,
                          flags_r.fast_int, flags_r.pri_run};

    always_comb
    begin
        gate_nxt  = gate_r;
        ctrl_nxt  = ctrl_r;
        rdata_nxt = 8'h00;
        if (wr_i)
        begin
            if (addr_i == `PGW_OFS_GATE_A)
                gate_nxt.a = wr_data_i & MASK_A;
            else if (addr_i == `PGW_OFS_GATE_B)
                gate_nxt.b = wr_data_i & MASK_B;
            else if (addr_i == `PGW_OFS_GATE_C)
                gate_nxt.c = wr_data_i & MASK_C;
            else if (addr_i == `PGW_OFS_CTRL)
                ctrl_nxt = wr_data_i;
        end
        // instruction overrides a same-cycle software write
        if (instr_w && src_w == PGW_SRC_INT)
            ctrl_nxt[`PGW_CTRL_INTERNAL_FREQ_SELECT_LO +: 3] = `PGW_INTERNAL_FREQ_SELECT_ON_CLEAR;
        if (rd_i)
        begin
            if (addr_i == `PGW_OFS_GATE_A)
                rdata_nxt = gate_r.a;
            else if (addr_i == `PGW_OFS_GATE_B)
                rdata_nxt = gate_r.b;
            else if (addr_i == `PGW_OFS_GATE_C)
                rdata_nxt = gate_r.c;
            else if (addr_i == `PGW_OFS_CTRL)
                rdata_nxt = ctrl_r;
            else if (addr_i == `PGW_OFS_STAT)
                rdata_nxt = stat_w;
        end
        clk_en_nxt = ~gate_nxt;
        hold_nxt   = gate_nxt;
        active_nxt = ~gate_nxt & unit_function_enable_i;
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            gate_r   <= {`PGW_GATE_RST, `PGW_GATE_RST, `PGW_GATE_RST};
            ctrl_r   <= `PGW_CTRL_RST;
            rdata_r  <= 8'h00;
            clk_en_r <= 24'hffffff;
            hold_r   <= 24'h000000;
            active_r <= 24'h000000;
        end
        else
        begin
            gate_r   <= gate_nxt;
            ctrl_r   <= ctrl_nxt;
            rdata_r  <= rdata_nxt;
            clk_en_r <= clk_en_nxt;
            hold_r   <= hold_nxt;
            active_r <= active_nxt;
        end
    end

    always_comb
    begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        flags_nxt     = flags_r;
        idle_nxt      = idle_r;
        need_ost_nxt  = need_ost_r;
        pending_nxt   = pending_r;
        cause_irq_nxt = cause_irq_r;
        cause_wdt_nxt = cause_wdt_r;
        int_sel_nxt   = int_sel_r;
        osc_en_nxt    = osc_en_r;
        branch_nxt    = 1'b0;
        wdt_rst_nxt   = 1'b0;
        wdt_clr_nxt   = instr_w;
        case (state_r)
            PGW_ST_BOOT:
            begin
                osc_en_nxt = 1'b1;
                if (src_w == PGW_SRC_INT)
                begin
                    state_nxt          = PGW_ST_RUN;
                    int_sel_nxt        = 1'b1;
                    flags_nxt.fast_int = (ctrl_r[`PGW_CTRL_INTERNAL_FREQ_SELECT_LO +: 3] != 3'h0);
                    flags_nxt.mid_int  = (ctrl_r[`PGW_CTRL_INTERNAL_FREQ_SELECT_LO +: 3] == 3'h0);
                end
                else if (src_w == PGW_SRC_EXT || primary_ready_i)
                begin
                    state_nxt         = PGW_ST_RUN;
                    int_sel_nxt       = 1'b0;
                    flags_nxt.pri_run = 1'b1;
                end
                else if (two_speed_w)
                begin
                    state_nxt   = PGW_ST_RUN;
                    int_sel_nxt = 1'b1;
                    pending_nxt = 1'b1;
                end
            end
            PGW_ST_RUN:
            begin
                if (pending_r && primary_ready_i)
                begin
                    pending_nxt       = 1'b0;
                    int_sel_nxt       = 1'b0;
                    flags_nxt.pri_run = 1'b1;
                end
                if (instr_w && ctrl_r[`PGW_CTRL_FAILSAFE])
                begin
                    flags_nxt.pri_run = 1'b0;
                    int_sel_nxt       = 1'b1;
                end
                if (wdt_timeout_i)
                begin
                    wdt_rst_nxt = 1'b1;
                    state_nxt   = PGW_ST_BOOT;
                    pending_nxt = 1'b0;
                    flags_nxt   = '0;
                end
                else if (sleep_instr_i)
                begin
                    state_nxt = PGW_ST_SLEEP;
                    idle_nxt  = ctrl_r[`PGW_CTRL_IDLE];
                    if (!ctrl_r[`PGW_CTRL_IDLE] || pending_r)
                    begin
                        osc_en_nxt  = 1'b0;
                        pending_nxt = 1'b0;
                        flags_nxt   = '0;
                    end
                end
            end
            PGW_ST_SLEEP:
            begin
                if (irq_wake_i || wdt_timeout_i)
                begin
                    state_nxt     = PGW_ST_WAKE;
                    cnt_nxt       = '0;
                    cause_irq_nxt = irq_wake_i;
                    cause_wdt_nxt = !irq_wake_i;
                    osc_en_nxt    = 1'b1;
                    need_ost_nxt  = !osc_en_r &&
                                    (src_w == PGW_SRC_XTAL || src_w == PGW_SRC_PLL);
                end
            end
            PGW_ST_WAKE:
            begin
                // ready delay counts from the wake event, alongside the startup wait
                if (cnt_r != READY_LAST)
                    cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == READY_LAST &&
                    (!need_ost_r || primary_ready_i || two_speed_w))
                begin
                    state_nxt  = PGW_ST_RUN;
                    branch_nxt = cause_irq_r && global_irq_enable_i;
                    if (need_ost_r && !primary_ready_i)
                    begin
                        pending_nxt = 1'b1;
                        int_sel_nxt = 1'b1;
                    end
                    else if (src_w == PGW_SRC_INT)
                    begin
                        int_sel_nxt        = 1'b1;
                        flags_nxt.fast_int = (ctrl_r[`PGW_CTRL_INTERNAL_FREQ_SELECT_LO +: 3] != 3'h0);
                        flags_nxt.mid_int  = (ctrl_r[`PGW_CTRL_INTERNAL_FREQ_SELECT_LO +: 3] == 3'h0);
                    end
                    else
                    begin
                        int_sel_nxt       = 1'b0;
                        flags_nxt.pri_run = 1'b1;
                    end
                end
            end
            default:
            begin
                state_nxt = PGW_ST_BOOT;
            end
        endcase
        run_nxt = (state_nxt == PGW_ST_RUN);
        rst_nxt = (state_nxt == PGW_ST_BOOT);
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r     <= PGW_ST_BOOT;
            cnt_r       <= '0;
            flags_r     <= '0;
            idle_r      <= 1'b0;
            need_ost_r  <= 1'b0;
            pending_r   <= 1'b0;
            cause_irq_r <= 1'b0;
            cause_wdt_r <= 1'b0;
            int_sel_r   <= 1'b0;
            osc_en_r    <= 1'b1;
            run_r       <= 1'b0;
            rst_r       <= 1'b1;
            branch_r    <= 1'b0;
            wdt_rst_r   <= 1'b0;
            wdt_clr_r   <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            flags_r     <= flags_nxt;
            idle_r      <= idle_nxt;
            need_ost_r  <= need_ost_nxt;
            pending_r   <= pending_nxt;
            cause_irq_r <= cause_irq_nxt;
            cause_wdt_r <= cause_wdt_nxt;
            int_sel_r   <= int_sel_nxt;
            osc_en_r    <= osc_en_nxt;
            run_r       <= run_nxt;
            rst_r       <= rst_nxt;
            branch_r    <= branch_nxt;
            wdt_rst_r   <= wdt_rst_nxt;
            wdt_clr_r   <= wdt_clr_nxt;
        end
    end

    assign rd_data_o          = rdata_r;
    assign periph_clk_en_o    = clk_en_r;
    assign periph_hold_o      = hold_r;
    assign periph_active_o    = active_r;
    assign cpu_run_o          = run_r;
    assign cpu_reset_o        = rst_r;
    assign irq_branch_o       = branch_r;
    assign wdt_reset_o        = wdt_rst_r;
    assign wdt_clear_o        = wdt_clr_r;
    assign primary_osc_en_o   = osc_en_r;
    assign internal_clk_sel_o = int_sel_r;

    gate_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (wr_i && addr_i == `PGW_OFS_GATE_A) |=> (periph_hold_o[7:0] == $past(wr_data_i)
        && periph_clk_en_o[7:0] == ~$past(wr_data_i)))
        else $error("gate write not reflected on hold and clock enable");

    unimpl_zero_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (rd_i && addr_i == `PGW_OFS_GATE_C) |=> (rd_data_o[7:4] == 4'h0))
        else $error("unimplemented gate bits read nonzero");

    variant_bits_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (PKG_PINS != 64) |-> !gate_r.c[3] && ((PKG_PINS != 28) || !gate_r.b[7]))
        else $error("absent variant gate bit set");

    sleep_stays_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_r == PGW_ST_SLEEP && !irq_wake_i && !wdt_timeout_i)
        |=> (state_r == PGW_ST_SLEEP) && !cpu_run_o)
        else $error("left sleep without trigger");

    irq_wake_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_r == PGW_ST_SLEEP && irq_wake_i) |=> (state_r == PGW_ST_WAKE) ##1 !cpu_run_o)
        else $error("interrupt did not start wake");

    wdt_run_reset_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_r == PGW_ST_RUN && wdt_timeout_i) |=> wdt_reset_o && cpu_reset_o)
        else $error("run mode time-out without reset");

    wdt_clear_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_r == PGW_ST_RUN && sleep_instr_i) |=> wdt_clear_o)
        else $error("sleep did not clear watchdog");

    ready_delay_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_r == PGW_ST_WAKE && cnt_r != READY_LAST) |=> !cpu_run_o)
        else $error("cpu resumed before ready delay");

    branch_gie_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        irq_branch_o |-> $rose(cpu_run_o) && $past(cause_irq_r) && $past(global_irq_enable_i))
        else $error("branch without irq wake and global enable");

    boot_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_r == PGW_ST_BOOT && src_w == PGW_SRC_XTAL && !two_speed_w && !primary_ready_i)
        |=> cpu_reset_o && !cpu_run_o)
        else $error("reset released before primary ready");

endmodule

`default_nettype wire

/* File: pgw_osc_model.sv */
`timescale 1ns/100ps
`default_nettype none

module pgw_osc_model
#(
    parameter int SLOW_CYC = 100
)
(
    input  wire logic clock_i,   // system clock
    input  wire logic reset_n_i, // device reset
    input  wire logic osc_en_i,  // primary oscillator enable
    input  wire logic slow_i,    // long start-up when high
    output logic      ready_o    // primary clock ready
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       ready_nxt;

    // a stopped oscillator loses ready at once and restarts from zero
    always_comb
    begin
        cnt_nxt   = !osc_en_i ? 8'h00 : (ready_o ? cnt_r : cnt_r + 8'h01);
        ready_nxt = osc_en_i && (cnt_r >= (slow_i ? 8'(SLOW_CYC) : 8'h04));
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_r   <= 8'h00;
            ready_o <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            ready_o <= ready_nxt;
        end
    end
endmodule

`default_nettype wire

/* File: periph_gating_and_wake_exit_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pgw_consts.svh"

module periph_gating_and_wake_exit_tb;
    logic        clock_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [7:0]  wr_data_i = 8'h00;
    logic        wr_i = 1'b0, rd_i = 1'b0, sleep_instr_i = 1'b0, wdt_clear_instr_i = 1'b0;
    logic        wdt_timeout_i = 1'b0, irq_wake_i = 1'b0, global_irq_enable_i = 1'b0;
    logic        slow = 1'b0;
    logic [23:0] unit_function_enable_i = 24'hffffff;
    logic [23:0] periph_clk_en_o, periph_hold_o, periph_active_o;
    logic [7:0]  rd_data_o, rd_small, d, ds;
    logic        primary_ready_i, cpu_run_o, cpu_reset_o, irq_branch_o, wdt_reset_o;
    logic        wdt_clear_o, primary_osc_en_o, internal_clk_sel_o;
    int          n_fail = 0, n_compared = 0, n;

    always #(`PGW_CLK_PERIOD_NS / 2.0) clock_i = ~clock_i;

    pgw_gate_wake #(.PKG_PINS(64)) dut_u (.clock_i, .reset_n_i, .addr_i, .wr_data_i, .wr_i,
        .rd_i, .rd_data_o, .unit_function_enable_i, .periph_clk_en_o, .periph_hold_o,
        .periph_active_o, .sleep_instr_i, .wdt_clear_instr_i, .wdt_timeout_i, .irq_wake_i,
        .global_irq_enable_i, .primary_ready_i, .cpu_run_o, .cpu_reset_o, .irq_branch_o,
        .wdt_reset_o, .wdt_clear_o, .primary_osc_en_o, .internal_clk_sel_o);

    // smallest package variant, same stimulus, only register reads compared
    pgw_gate_wake #(.PKG_PINS(28)) dut_small_u (.clock_i, .reset_n_i, .addr_i, .wr_data_i,
        .wr_i, .rd_i, .rd_data_o(rd_small), .unit_function_enable_i, .periph_clk_en_o(),
        .periph_hold_o(), .periph_active_o(), .sleep_instr_i, .wdt_clear_instr_i,
        .wdt_timeout_i, .irq_wake_i, .global_irq_enable_i, .primary_ready_i, .cpu_run_o(),
        .cpu_reset_o(), .irq_branch_o(), .wdt_reset_o(), .wdt_clear_o(),
        .primary_osc_en_o(), .internal_clk_sel_o());

    pgw_osc_model #(.SLOW_CYC(100)) osc_u (.clock_i, .reset_n_i, .osc_en_i(primary_osc_en_o),
        .slow_i(slow), .ready_o(primary_ready_i));

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr_i    <= a;
        wr_data_i <= v;
        wr_i      <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] m, e, es);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        d  = rd_data_o;
        ds = rd_small;
        chk("read", d & m, e);
        chk("read small", ds & m, es);
    endtask

    // trigger pulses are dropped at the first edge, then the resume is counted
    task automatic wake_wait();
        n = 0;
        do
        begin
            @(posedge clock_i);
            irq_wake_i    <= 1'b0;
            wdt_timeout_i <= 1'b0;
            #1;
            n++;
        end
        while (cpu_run_o !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            n_fail++;
            end_sim();
        end
    endtask

    task automatic wake(input logic by_irq);
        @(posedge clock_i);
        irq_wake_i    <= by_irq;
        wdt_timeout_i <= !by_irq;
        wake_wait();
    endtask

    task automatic go_sleep();
        @(posedge clock_i);
        sleep_instr_i <= 1'b1;
        @(posedge clock_i);
        sleep_instr_i <= 1'b0;
        #1;
        chk("cpu run asleep", cpu_run_o, 1'b0);
    endtask

    initial
    begin
        #2000000;
        n_fail++;
        end_sim();
    end

    initial
    begin
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b1;
        #1;
        chk("hold at reset", periph_hold_o, 24'h000000);
        chk("clk en at reset", periph_clk_en_o, 24'hffffff);
        chk("cpu held", cpu_reset_o, 1'b1);
        wake_wait();
        chk("cpu released", cpu_reset_o, 1'b0);
        rdchk(`PGW_OFS_GATE_A, 8'hff, 8'h00, 8'h00);
        rdchk(`PGW_OFS_GATE_B, 8'hff, 8'h00, 8'h00);
        rdchk(`PGW_OFS_GATE_C, 8'hff, 8'h00, 8'h00);
        wr(`PGW_OFS_GATE_A, 8'hff);
        wr(`PGW_OFS_GATE_B, 8'hff);
        wr(`PGW_OFS_GATE_C, 8'hff);
        rdchk(`PGW_OFS_GATE_A, 8'hff, 8'hff, 8'hff);
        rdchk(`PGW_OFS_GATE_B, 8'hff, 8'hff, 8'h7f);
        rdchk(`PGW_OFS_GATE_C, 8'hff, 8'h0f, 8'h07);
        @(posedge clock_i);
        #1;
        chk("read data idle", rd_data_o, 8'h00);
        chk("hold all", periph_hold_o, 24'h0fffff);
        chk("clk en all", periph_clk_en_o, 24'hf00000);
        chk("active all", periph_active_o, 24'hf00000);
        wr(4'hf, 8'hff);
        rdchk(4'hf, 8'hff, 8'h00, 8'h00);
        wr(`PGW_OFS_STAT, 8'hff);
        rdchk(`PGW_OFS_STAT, 8'hf9, 8'h01, 8'h01);
        wr(`PGW_OFS_GATE_A, 8'h5a);
        wr(`PGW_OFS_GATE_B, 8'h00);
        unit_function_enable_i <= 24'h00ffff;
        wr(`PGW_OFS_GATE_C, 8'h00);
        rdchk(`PGW_OFS_GATE_A, 8'hff, 8'h5a, 8'h5a);
        chk("hold part", periph_hold_o, 24'h00005a);
        chk("clk en part", periph_clk_en_o, 24'hffffa5);
        chk("active part", periph_active_o, 24'h00ffa5);
        // external source, no start-up wait
        wr(`PGW_OFS_CTRL, 8'h10);
        global_irq_enable_i <= 1'b1;
        @(posedge clock_i);
        wdt_clear_instr_i <= 1'b1;
        @(posedge clock_i);
        wdt_clear_instr_i <= 1'b0;
        #1;
        chk("wdt clear", wdt_clear_o, 1'b1);
        @(posedge clock_i);
        irq_wake_i <= 1'b1;
        @(posedge clock_i);
        irq_wake_i <= 1'b0;
        #1;
        chk("irq in run", {cpu_run_o, irq_branch_o}, 2'b10);
        go_sleep();
        wake(1'b1);
        chk("irq wake delay", n, `PGW_CPU_READY_CYC + 1);
        chk("branch gie", irq_branch_o, 1'b1);
        rdchk(`PGW_OFS_STAT, 8'h38, 8'h10, 8'h10);
        global_irq_enable_i <= 1'b0;
        go_sleep();
        wake(1'b1);
        chk("no branch", irq_branch_o, 1'b0);
        go_sleep();
        wake(1'b0);
        chk("wdt wake delay", n, `PGW_CPU_READY_CYC + 1);
        chk("wdt no branch", irq_branch_o, 1'b0);
        rdchk(`PGW_OFS_STAT, 8'h38, 8'h20, 8'h20);
        // crystal with slow start-up: delays overlap, not add
        wr(`PGW_OFS_CTRL, 8'h00);
        slow <= 1'b1;
        go_sleep();
        wake(1'b1);
        chk("startup wait", (n >= 100) && (n < 120), 1'b1);
        rdchk(`PGW_OFS_STAT, 8'h01, 8'h01, 8'h01);
        // fail-safe clear drops the primary clock while it is in use
        wr(`PGW_OFS_CTRL, 8'h04);
        @(posedge clock_i);
        wdt_clear_instr_i <= 1'b1;
        @(posedge clock_i);
        wdt_clear_instr_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk("failsafe clk", internal_clk_sel_o, 1'b1);
        rdchk(`PGW_OFS_STAT, 8'h01, 8'h00, 8'h00);
        wr(`PGW_OFS_CTRL, 8'h01);
        go_sleep();
        chk("idle osc on", primary_osc_en_o, 1'b1);
        wake(1'b1);
        chk("idle wake delay", n, `PGW_CPU_READY_CYC + 1);
        wr(`PGW_OFS_CTRL, 8'h02);
        go_sleep();
        wake(1'b1);
        chk("two speed delay", n, `PGW_CPU_READY_CYC + 1);
        chk("two speed clk", internal_clk_sel_o, 1'b1);
        wr(`PGW_OFS_CTRL, 8'h18);
        go_sleep();
        wake(1'b1);
        chk("internal delay", n, `PGW_CPU_READY_CYC + 1);
        rdchk(`PGW_OFS_CTRL, 8'hff, 8'h78, 8'h78);
        rdchk(`PGW_OFS_STAT, 8'h02, 8'h02, 8'h02);
        // time-out while running resets instead of waking
        @(posedge clock_i);
        wdt_timeout_i <= 1'b1;
        for (n = 0; n < 4 && wdt_reset_o !== 1'b1; n++)
        begin
            @(posedge clock_i);
            wdt_timeout_i <= 1'b0;
            #1;
        end
        chk("wdt reset seen", n < 4, 1'b1);
        // internal source reboots at the next edge, so look in the reset cycle
        chk("run stopped", cpu_run_o, 1'b0);
        chk("reset on time-out", cpu_reset_o, 1'b1);
        wake_wait();
        end_sim();
    end
endmodule

`default_nettype wire
